// *** core/asss_host.sv ***
// Behaviour
// [R1] Hold reset low, power-down high; then wait
// [R2] Trim by writing zero, wait fifty ms
// [R3] Configure audio path and registers, then exit
// [R4] Normal operation: volume, mute, shutdown only
// [R5] No shutdown change before first-trim hold-off
// [R6] Hold-off only after first trim since power-up
// [R7] Enter shutdown, wait 1 ms plus scaled stop
// [R8] Reconfigure while in shutdown, then exit
// [R9] Exit shutdown, wait 1 ms plus scaled start
// [R10] Ramp times come from timing register, scaled 1.3
// [R11] Sudden loss: power-down pin low, wait 2 ms
// [R12] Reset low 2 us before inputs go low
// [R13] Waits counted in cycles, ramp waits scaled from timing byte
`timescale 1ns/1ps
module asss_host #(
  parameter int unsigned RST_HOLD_CYC = asss_pkg::CYC_RST_HOLD,
  parameter int unsigned RST_WAIT_CYC = asss_pkg::CYC_RST_WAIT,
  parameter int unsigned TRIM_CYC = asss_pkg::CYC_TRIM,
  parameter int unsigned HOLDOFF_CYC = asss_pkg::CYC_HOLDOFF,
  parameter int unsigned SD_CYC = asss_pkg::CYC_SD,
  parameter int unsigned PDN_CYC = asss_pkg::CYC_PDN,
  parameter int unsigned RAMP_UNIT_CYC = 200_000,
  parameter int QDIV = 125,
  parameter logic [6:0] DEV_ADDR = 7'h2a,
  parameter logic [7:0] VOL_LO = 8'h07,
  parameter logic [7:0] VOL_HI = 8'h0a,
  parameter logic [7:0] MUTE_REG = 8'h06
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Amplifier control pins
  output logic rst_n_pin,
  output logic power_down_pin,
  output logic inputs_en,
  // Two-wire bus
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  localparam int unsigned SCALED_STEP = (RAMP_UNIT_CYC * 13 + 9) / 10;

  asss_pkg::asss_state_t state_q, state_d;
  asss_pkg::asss_req_t wr_req_q, i2c_req;
  logic [31:0] cnt_q, cnt_d, ho_q, age_q, ramp_up_cyc, ramp_dn_cyc;
  logic [7:0] timing_q;
  logic [asss_pkg::NCMD-1:0] cmd_q, cmd_ok, cmd_take;
  logic wr_pend_q, launched_q, trimmed_q, first_done_q, refused_q, nack_q;
  logic i2c_go, i2c_busy, i2c_done, i2c_nack, seq_wr, user_go, idle;
  logic wr_ok, wr_refuse, cmd_wr, wr_wr, st_wr, setup, allowed;
  logic [31:0] rd_d;
  logic rst_n_q, pdn_q, in_en_q;

  // Ramp waits scaled by 1.3 from the programmed timing byte
  assign ramp_up_cyc = SD_CYC + 32'(timing_q[asss_pkg::RAMP_UP_LSB +: 4]) * SCALED_STEP; // [R10] [R13]
  assign ramp_dn_cyc = SD_CYC + 32'(timing_q[asss_pkg::RAMP_DN_LSB +: 4]) * SCALED_STEP; // [R10] [R13]

  // Bus decode
  assign setup = psel && !penable;
  assign cmd_wr = psel && penable && pwrite && (paddr == asss_pkg::A_CTRL);
  assign wr_wr = psel && penable && pwrite && (paddr == asss_pkg::A_WRITE);
  assign st_wr = psel && penable && pwrite && (paddr == asss_pkg::A_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr == asss_pkg::A_CTRL || paddr == asss_pkg::A_WRITE
                   || paddr == asss_pkg::A_STATUS || paddr == asss_pkg::A_TIMING);

  // Registers allowed while running
  assign allowed = (pwdata[15:8] >= VOL_LO && pwdata[15:8] <= VOL_HI)
                   || pwdata[15:8] == MUTE_REG; // [R4]
  assign wr_ok = !wr_pend_q && (state_q == asss_pkg::ST_CONFIG
                 || state_q == asss_pkg::ST_SHUTDOWN
                 || (state_q == asss_pkg::ST_RUN && allowed)) // [R4] [R8]
                 && !(pwdata[15:8] == asss_pkg::DEV_SHUTDOWN_CONTROL && ho_q != 32'h0); // [R5]
  assign wr_refuse = wr_wr && !wr_ok;

  // Command legality against the present state
  always_comb begin
    cmd_ok = '0;
    cmd_ok[asss_pkg::C_STARTUP] = state_q == asss_pkg::ST_OFF || state_q == asss_pkg::ST_DOWN;
    cmd_ok[asss_pkg::C_ENTER_SD] = state_q == asss_pkg::ST_RUN && ho_q == 32'h0; // [R5]
    cmd_ok[asss_pkg::C_EXIT_SD] = (state_q == asss_pkg::ST_CONFIG
                                  || state_q == asss_pkg::ST_SHUTDOWN)
                                  && ho_q == 32'h0 && trimmed_q; // [R3] [R5]
    cmd_ok[asss_pkg::C_POWER_DOWN] = state_q == asss_pkg::ST_RUN
                                     || state_q == asss_pkg::ST_CONFIG
                                     || state_q == asss_pkg::ST_SHUTDOWN;
    cmd_ok[asss_pkg::C_POWER_LOSS] = !(state_q == asss_pkg::ST_OFF
                                     || state_q == asss_pkg::ST_DOWN
                                     || state_q == asss_pkg::ST_PDN_WAIT
                                     || state_q == asss_pkg::ST_RST_LOW);
  end

  // Pending commands, dropped when taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= '0;
    end else if (cmd_wr) begin
      cmd_q <= (cmd_q & ~cmd_take) | (pwdata[asss_pkg::NCMD-1:0] & cmd_ok);
    end else begin
      cmd_q <= cmd_q & ~cmd_take;
    end
  end

  // Pending device write from software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_pend_q <= 1'b0;
      wr_req_q <= '0;
    end else if (wr_wr && wr_ok) begin
      wr_pend_q <= 1'b1;
      wr_req_q <= pwdata[15:0];
    end else if (user_go) begin
      wr_pend_q <= 1'b0;
    end
  end

  // Copy of the timing byte last sent to the amplifier
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timing_q <= asss_pkg::TIMING_RST;
    end else if (user_go && wr_req_q.reg_addr == asss_pkg::DEV_PWM_START_STOP_TIMING) begin
      timing_q <= wr_req_q.data; // [R10]
    end
  end

  // Sticky flags, a new event wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refused_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      refused_q <= wr_refuse || (cmd_wr && |(pwdata[asss_pkg::NCMD-1:0] & ~cmd_ok))
                   || (refused_q && !(st_wr && pwdata[asss_pkg::S_REFUSED]));
      nack_q <= (i2c_done && i2c_nack) || (nack_q && !(st_wr && pwdata[asss_pkg::S_NACK]));
    end
  end

  // Read data captured in the setup cycle
  always_comb begin
    rd_d = 32'h0;
    case (paddr)
      asss_pkg::A_CTRL: rd_d[asss_pkg::NCMD-1:0] = cmd_q;
      asss_pkg::A_WRITE: rd_d[15:0] = wr_req_q;
      asss_pkg::A_TIMING: rd_d[7:0] = timing_q;
      asss_pkg::A_STATUS: begin
        rd_d[3:0] = state_q;
        rd_d[asss_pkg::S_BUSY] = i2c_busy;
        rd_d[asss_pkg::S_HOLDOFF] = ho_q != 32'h0;
        rd_d[asss_pkg::S_TRIMMED] = trimmed_q;
        rd_d[asss_pkg::S_REFUSED] = refused_q;
        rd_d[asss_pkg::S_NACK] = nack_q;
        rd_d[asss_pkg::S_WR_PEND] = wr_pend_q;
      end
      default: rd_d = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (setup) begin
      prdata <= rd_d;
    end
  end

  // Write launches: sequencer writes once per state, user writes in idle states
  assign seq_wr = state_q == asss_pkg::ST_TRIM || state_q == asss_pkg::ST_EXIT_WR
                  || state_q == asss_pkg::ST_ENTER_WR;
  assign idle = !i2c_busy && !launched_q;
  assign user_go = wr_pend_q && !i2c_busy && (state_q == asss_pkg::ST_CONFIG
                   || state_q == asss_pkg::ST_SHUTDOWN || state_q == asss_pkg::ST_RUN); // [R4]
  assign i2c_go = (seq_wr && idle) || user_go;

  always_comb begin
    case (state_q)
      asss_pkg::ST_TRIM: i2c_req = {asss_pkg::DEV_OSCILLATOR_TRIM, asss_pkg::TRIM_VAL}; // [R2]
      asss_pkg::ST_EXIT_WR: i2c_req = {asss_pkg::DEV_SHUTDOWN_CONTROL, asss_pkg::SD_EXIT_VAL}; // [R9]
      asss_pkg::ST_ENTER_WR: i2c_req = {asss_pkg::DEV_SHUTDOWN_CONTROL, asss_pkg::SD_ENTER_VAL}; // [R7]
      default: i2c_req = wr_req_q;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      launched_q <= 1'b0;
    end else if (state_q != state_d) begin
      launched_q <= 1'b0;
    end else if (seq_wr && i2c_go) begin
      launched_q <= 1'b1;
    end
  end

  // Next state and wait count on entry
  always_comb begin
    state_d = state_q;
    cmd_take = '0;
    if (cmd_q[asss_pkg::C_POWER_LOSS]) begin
      state_d = asss_pkg::ST_PDN_WAIT; // [R11]
      cmd_take = '1;
    end else begin
      case (state_q)
        asss_pkg::ST_OFF, asss_pkg::ST_DOWN: begin
          cmd_take[asss_pkg::C_STARTUP] = 1'b1;
          if (cmd_q[asss_pkg::C_STARTUP]) state_d = asss_pkg::ST_RST_HOLD;
        end
        asss_pkg::ST_RST_HOLD: if (cnt_q == 32'h0) state_d = asss_pkg::ST_RST_WAIT; // [R1]
        asss_pkg::ST_RST_WAIT: if (cnt_q == 32'h0) state_d = asss_pkg::ST_TRIM; // [R1]
        asss_pkg::ST_TRIM: if (i2c_done) state_d = asss_pkg::ST_TRIM_WAIT;
        asss_pkg::ST_TRIM_WAIT: if (cnt_q == 32'h0) state_d = asss_pkg::ST_CONFIG; // [R2]
        asss_pkg::ST_CONFIG, asss_pkg::ST_SHUTDOWN: begin
          if (!i2c_busy && !wr_pend_q) begin
            cmd_take[asss_pkg::C_EXIT_SD] = 1'b1;
            cmd_take[asss_pkg::C_POWER_DOWN] = 1'b1;
            if (cmd_q[asss_pkg::C_POWER_DOWN]) state_d = asss_pkg::ST_RST_LOW;
            else if (cmd_q[asss_pkg::C_EXIT_SD]) state_d = asss_pkg::ST_EXIT_WR; // [R3] [R8]
          end
        end
        asss_pkg::ST_EXIT_WR: if (i2c_done) state_d = asss_pkg::ST_EXIT_WAIT;
        asss_pkg::ST_EXIT_WAIT: if (cnt_q == 32'h0) state_d = asss_pkg::ST_RUN; // [R9]
        asss_pkg::ST_RUN: begin
          if (!i2c_busy && !wr_pend_q) begin
            cmd_take[asss_pkg::C_ENTER_SD] = 1'b1;
            cmd_take[asss_pkg::C_POWER_DOWN] = 1'b1;
            if (cmd_q[asss_pkg::C_ENTER_SD] || cmd_q[asss_pkg::C_POWER_DOWN]) begin
              state_d = asss_pkg::ST_ENTER_WR; // [R7]
            end
          end
        end
        asss_pkg::ST_ENTER_WR: if (i2c_done) state_d = asss_pkg::ST_ENTER_WAIT;
        asss_pkg::ST_ENTER_WAIT: if (cnt_q == 32'h0) state_d = asss_pkg::ST_SHUTDOWN; // [R7]
        asss_pkg::ST_PDN_WAIT: if (cnt_q == 32'h0) state_d = asss_pkg::ST_RST_LOW; // [R11]
        asss_pkg::ST_RST_LOW: if (cnt_q == 32'h0) state_d = asss_pkg::ST_DOWN; // [R12]
        default: state_d = asss_pkg::ST_OFF;
      endcase
    end
    case (state_d)
      asss_pkg::ST_RST_HOLD: cnt_d = RST_HOLD_CYC - 32'h1;
      asss_pkg::ST_RST_WAIT: cnt_d = RST_WAIT_CYC - 32'h1;
      asss_pkg::ST_TRIM_WAIT: cnt_d = TRIM_CYC - 32'h1;
      asss_pkg::ST_EXIT_WAIT: cnt_d = ramp_up_cyc - 32'h1; // [R9] [R13]
      asss_pkg::ST_ENTER_WAIT: cnt_d = ramp_dn_cyc - 32'h1; // [R7] [R13]
      asss_pkg::ST_PDN_WAIT: cnt_d = PDN_CYC - 32'h1;
      asss_pkg::ST_RST_LOW: cnt_d = asss_pkg::CYC_RST_LOW - 32'h1;
      default: cnt_d = 32'h0;
    endcase
  end

  // Sequencer state and wait counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= asss_pkg::ST_OFF;
      cnt_q <= 32'h0;
    end else begin
      state_q <= state_d;
      if (state_q != state_d) cnt_q <= cnt_d;
      else if (cnt_q != 32'h0) cnt_q <= cnt_q - 32'h1;
    end
  end

  // Hold-off after the first trim since power-up only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ho_q <= 32'h0;
      first_done_q <= 1'b0;
      trimmed_q <= 1'b0;
    end else begin
      if (state_q == asss_pkg::ST_TRIM && i2c_done) begin
        trimmed_q <= 1'b1;
        first_done_q <= 1'b1; // [R6]
      end else if (state_q == asss_pkg::ST_RST_HOLD) begin
        trimmed_q <= 1'b0;
      end
      if (state_q == asss_pkg::ST_TRIM && i2c_done && !first_done_q) begin
        ho_q <= HOLDOFF_CYC + ramp_up_cyc - SD_CYC; // [R5] [R6]
      end else if (ho_q != 32'h0) begin
        ho_q <= ho_q - 32'h1;
      end
    end
  end

  // Pin levels per state, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_n_q <= 1'b0;
      pdn_q <= 1'b0;
      in_en_q <= 1'b0;
    end else begin
      rst_n_q <= !(state_d == asss_pkg::ST_OFF || state_d == asss_pkg::ST_RST_HOLD
                 || state_d == asss_pkg::ST_RST_LOW || state_d == asss_pkg::ST_DOWN); // [R1] [R12]
      pdn_q <= !(state_d == asss_pkg::ST_OFF || state_d == asss_pkg::ST_DOWN
               || state_d == asss_pkg::ST_PDN_WAIT
               || (state_d == asss_pkg::ST_RST_LOW && !pdn_q)); // [R11]
      in_en_q <= !(state_d == asss_pkg::ST_OFF || state_d == asss_pkg::ST_DOWN); // [R12]
    end
  end

  assign rst_n_pin = rst_n_q;
  assign power_down_pin = pdn_q;
  assign inputs_en = in_en_q;

  asss_i2c_wr #(.QDIV(QDIV)) u_wr (
    .pclk(pclk),
    .presetn(presetn),
    .go(i2c_go),
    .dev_addr(DEV_ADDR),
    .req(i2c_req),
    .busy(i2c_busy),
    .done(i2c_done),
    .nack(i2c_nack),
    .scl_in(scl_in),
    .scl_out(scl_out),
    .scl_oe(scl_oe),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe)
  );

  // Cycles spent in the present state, for the checks below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) age_q <= 32'h0;
    else if (state_q != state_d) age_q <= 32'h0;
    else age_q <= age_q + 32'h1;
  end

  rst_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    state_q == asss_pkg::ST_RST_HOLD && state_d == asss_pkg::ST_RST_WAIT
      |-> age_q >= RST_HOLD_CYC - 1
      ##1 rst_n_pin && power_down_pin)
    else $error("reset released early");
  trim_wait_a: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    state_q == asss_pkg::ST_TRIM_WAIT && state_d == asss_pkg::ST_CONFIG
      |-> age_q >= TRIM_CYC - 1)
    else $error("trim wait too short");
  exit_order_a: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    i2c_go && state_q == asss_pkg::ST_EXIT_WR |-> trimmed_q && $past(state_q) != asss_pkg::ST_RUN)
    else $error("exit before configuration");
  run_events_a: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    user_go && state_q == asss_pkg::ST_RUN |-> (i2c_req.reg_addr >= VOL_LO
      && i2c_req.reg_addr <= VOL_HI) || i2c_req.reg_addr == MUTE_REG)
    else $error("illegal write while running");
  holdoff_a: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    i2c_go && i2c_req.reg_addr == asss_pkg::DEV_SHUTDOWN_CONTROL && !i2c_busy |-> ho_q == 32'h0)
    else $error("shutdown change inside hold-off");
  first_trim_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    state_q == asss_pkg::ST_TRIM && i2c_done && first_done_q |=> ho_q == $past(ho_q) - 1
      || $past(ho_q) == 32'h0)
    else $error("hold-off reloaded by later trim");
  enter_wait_a: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
    state_q == asss_pkg::ST_ENTER_WAIT && state_d == asss_pkg::ST_SHUTDOWN
      |-> age_q >= ramp_dn_cyc - 1)
    else $error("shutdown entry wait too short");
  exit_wait_a: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
    state_q == asss_pkg::ST_EXIT_WAIT && state_d == asss_pkg::ST_RUN
      |-> age_q >= ramp_up_cyc - 1)
    else $error("shutdown exit wait too short");
  pdn_wait_a: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
    state_q == asss_pkg::ST_PDN_WAIT && state_d != state_q |-> age_q >= PDN_CYC - 1
      ##1 !power_down_pin && !rst_n_pin)
    else $error("power-down pin wait too short");
  rst_low_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
    $fell(inputs_en) |-> $past(!rst_n_pin) && $past(age_q) >= asss_pkg::CYC_RST_LOW - 2)
    else $error("inputs dropped before reset low time");
endmodule // asss_host

// *** core/asss_i2c_wr.sv ***
`timescale 1ns/1ps
// Three-byte register write on an open-drain two-wire bus
module asss_i2c_wr #(
  parameter int QDIV = 125
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request
  input wire logic go,
  input wire logic [6:0] dev_addr,
  input asss_pkg::asss_req_t req,
  output logic busy,
  output logic done,
  output logic nack,
  // Bus pins, enable high pulls the line low
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  logic [26:0] frame_q;
  logic [4:0] idx_q;
  logic [1:0] qtr_q;
  logic [15:0] div_q;
  logic busy_q, done_q, nack_q, scl_oe_q, sda_oe_q;
  logic tick, scl_low, sda_low, ack_slot;

  assign tick = (div_q == 16'(QDIV - 1));
  assign ack_slot = (idx_q == 5'd9) || (idx_q == 5'd18) || (idx_q == 5'd27);

  // Bit and quarter sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      idx_q <= 5'd0;
      qtr_q <= 2'd0;
      div_q <= 16'h0000;
      frame_q <= 27'h0;
    end else begin
      done_q <= 1'b0;
      if (!busy_q && go) begin
        busy_q <= 1'b1;
        idx_q <= 5'd0;
        qtr_q <= 2'd0;
        div_q <= 16'h0000;
        frame_q <= {dev_addr, 1'b0, 1'b1, req.reg_addr, 1'b1, req.data, 1'b1};
      end else if (busy_q) begin
        div_q <= tick ? 16'h0000 : div_q + 16'h0001;
        if (tick) begin
          qtr_q <= qtr_q + 2'd1;
          if (qtr_q == 2'd3) begin
            idx_q <= idx_q + 5'd1;
            if (idx_q != 5'd0) begin
              frame_q <= {frame_q[25:0], 1'b1};
            end
            if (idx_q == 5'd28) begin
              busy_q <= 1'b0;
              done_q <= 1'b1;
            end
          end
        end
      end
    end
  end

  // Acknowledge sampling, sticky per write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nack_q <= 1'b0;
    end else if (!busy_q && go) begin
      nack_q <= 1'b0;
    end else if (busy_q && tick && qtr_q == 2'd2 && ack_slot && sda_in) begin
      nack_q <= 1'b1;
    end
  end

  // Line levels for start, data and stop symbols
  always_comb begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    if (busy_q) begin
      if (idx_q == 5'd0) begin
        scl_low = (qtr_q == 2'd3);
        sda_low = qtr_q[1];
      end else if (idx_q == 5'd28) begin
        scl_low = (qtr_q == 2'd0);
        sda_low = !qtr_q[1];
      end else begin
        scl_low = (qtr_q == 2'd0) || (qtr_q == 2'd3);
        sda_low = !frame_q[26];
      end
    end
  end

  // Registered pin drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      scl_oe_q <= scl_low;
      sda_oe_q <= sda_low;
    end
  end

  assign busy = busy_q;
  assign done = done_q;
  assign nack = nack_q;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
endmodule // asss_i2c_wr

// *** core/asss_pkg.sv ***
package asss_pkg;
  // Clock
  localparam int unsigned CLK_PERIOD_NS = 5;
  // Minimum waits, as printed
  localparam int unsigned T_RST_HOLD_NS = 100_000;     // 100 us
  localparam int unsigned T_RST_WAIT_NS = 13_500_000;  // 13.5 ms
  localparam int unsigned T_TRIM_NS = 50_000_000;      // 50 ms
  localparam int unsigned T_HOLDOFF_NS = 240_000_000;  // 240 ms
  localparam int unsigned T_SD_NS = 1_000_000;         // 1 ms
  localparam int unsigned T_PDN_NS = 2_000_000;        // 2 ms
  localparam int unsigned T_RST_LOW_NS = 2_000;        // 2 us
  // Cycle counts, rounded up
  localparam int unsigned CYC_RST_HOLD = (T_RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_RST_WAIT = (T_RST_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_TRIM = (T_TRIM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_HOLDOFF = (T_HOLDOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_SD = (T_SD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_PDN = (T_PDN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_RST_LOW = (T_RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Amplifier registers and values
  localparam logic [7:0] DEV_SHUTDOWN_CONTROL = 8'h05;
  localparam logic [7:0] DEV_PWM_START_STOP_TIMING = 8'h1a;
  localparam logic [7:0] DEV_OSCILLATOR_TRIM = 8'h1b;
  localparam logic [7:0] SD_ENTER_VAL = 8'h40;
  localparam logic [7:0] SD_EXIT_VAL = 8'h00;
  localparam logic [7:0] TRIM_VAL = 8'h00;
  // Ramp time fields inside the timing byte
  localparam int RAMP_UP_LSB = 4;
  localparam int RAMP_DN_LSB = 0;
  localparam logic [7:0] TIMING_RST = 8'h00;
  // Host register offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_WRITE = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_TIMING = 8'h0c;
  // Command bits of the control register
  localparam int C_STARTUP = 0;
  localparam int C_ENTER_SD = 1;
  localparam int C_EXIT_SD = 2;
  localparam int C_POWER_DOWN = 3;
  localparam int C_POWER_LOSS = 4;
  localparam int NCMD = 5;
  // Status bits
  localparam int S_BUSY = 4;
  localparam int S_HOLDOFF = 5;
  localparam int S_TRIMMED = 6;
  localparam int S_REFUSED = 7;
  localparam int S_NACK = 8;
  localparam int S_WR_PEND = 9;

  // One register write to the amplifier
  typedef struct packed {
    logic [7:0] reg_addr;
    logic [7:0] data;
  } asss_req_t;

  // Sequencer states, Gray along the usual path
  typedef enum logic [3:0] {
    ST_OFF = 4'h0,
    ST_RST_HOLD = 4'h1,
    ST_RST_WAIT = 4'h3,
    ST_TRIM = 4'h2,
    ST_TRIM_WAIT = 4'h6,
    ST_CONFIG = 4'h7,
    ST_EXIT_WR = 4'h5,
    ST_EXIT_WAIT = 4'h4,
    ST_RUN = 4'hc,
    ST_ENTER_WR = 4'hd,
    ST_ENTER_WAIT = 4'hf,
    ST_SHUTDOWN = 4'he,
    ST_PDN_WAIT = 4'ha,
    ST_RST_LOW = 4'hb,
    ST_DOWN = 4'h9
  } asss_state_t;
endpackage

// *** verification/amp_startup_shutdown_sequencer_tb.sv ***
`timescale 1ns/1ps
module amp_startup_shutdown_sequencer_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, scl, sda;
  logic rst_n_pin, power_down_pin, inputs_en, scl_out, scl_oe, sda_out, sda_oe, ack_oe;
  logic [7:0] paddr, last_reg, last_data, t, v;
  logic [31:0] pwdata, prdata, rd;
  int nwr, seen, n, mismatches, comparisons;
  // Open-drain wires with pull-ups
  assign scl = !scl_oe;
  assign sda = !(sda_oe || ack_oe);
  // Shortened waits so the run stays brief
  localparam int unsigned SHORT_CYC = 20;
  localparam int unsigned LONG_CYC = 30;
  asss_host #(.RST_HOLD_CYC(SHORT_CYC), .RST_WAIT_CYC(SHORT_CYC), .TRIM_CYC(LONG_CYC),
    .HOLDOFF_CYC(2000), .SD_CYC(SHORT_CYC), .PDN_CYC(LONG_CYC), .RAMP_UNIT_CYC(10),
    .QDIV(2)) dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rst_n_pin,
    .power_down_pin, .inputs_en, .scl_in(scl), .scl_out, .scl_oe, .sda_in(sda), .sda_out,
    .sda_oe);
  asss_amp_model amp_m (.scl, .sda, .ack_oe, .last_reg, .last_data, .nwr);
  // Clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Poll status until the masked bits match
  task automatic wt(input logic [31:0] m, input logic [31:0] e);
    for (int i = 0; i < 5000; i++) begin
      apb(1'b0, asss_pkg::A_STATUS, 32'h0);
      if ((rd & m) === e) break;
    end
    cmp("status", e, rd & m);
  endtask
  // Next register write seen by the amplifier
  task automatic amp(input logic [7:0] r, input logic [7:0] d);
    for (int i = 0; i < 2000 && nwr <= seen; i++) @(posedge pclk);
    if (nwr <= seen) mismatches++;
    seen++;
    cmp("amp write", {r, d}, {last_reg, last_data});
  endtask
  task automatic span(ref logic s);
    for (n = 0; s !== 1'b0 && n < 3000; n++) @(posedge pclk);
    if (s !== 1'b0) mismatches++;
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    end_sim();
  end
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(32'h19f9));
    seen = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h20, 32'h0);
    cmp("unmapped", 32'h1, {31'h0, err});
    cmp("reset pins", 32'h0, {rst_n_pin, power_down_pin, inputs_en});
    apb(1'b1, asss_pkg::A_CTRL, 32'h1);
    wt(32'hf, 32'h1);
    cmp("hold pins", 32'h1, {rst_n_pin, power_down_pin});
    wt(32'hf, 32'h7);
    amp(8'h1b, 8'h00);
    cmp("holdoff", 32'h20, rd & 32'h20);
    apb(1'b1, asss_pkg::A_CTRL, 32'h4);
    wt(32'h80, 32'h80);
    apb(1'b1, asss_pkg::A_STATUS, 32'h80);
    t = 8'($urandom) & 8'h33;
    apb(1'b1, asss_pkg::A_WRITE, {16'h0, 8'h1a, t});
    amp(8'h1a, t);
    apb(1'b0, asss_pkg::A_TIMING, 32'h0);
    cmp("timing", {24'h0, t}, rd);
    wt(32'h20, 32'h0);
    apb(1'b1, asss_pkg::A_CTRL, 32'h4);
    amp(8'h05, 8'h00);
    wt(32'hf, 32'hc);
    v = 8'(7 + $urandom % 4);
    t = 8'($urandom);
    apb(1'b1, asss_pkg::A_WRITE, {16'h0, v, t});
    amp(v, t);
    apb(1'b1, asss_pkg::A_WRITE, {16'h0, 8'h1b, t});
    wt(32'h80, 32'h80);
    cmp("no write", seen, nwr);
    apb(1'b1, asss_pkg::A_CTRL, 32'h2);
    amp(8'h05, 8'h40);
    wt(32'hf, 32'he);
    apb(1'b1, asss_pkg::A_CTRL, 32'h8);
    span(rst_n_pin);
    cmp("pdn kept", 32'h3, {power_down_pin, inputs_en});
    span(inputs_en);
    cmp("reset low span", 32'h1, n >= asss_pkg::CYC_RST_LOW);
    apb(1'b1, asss_pkg::A_CTRL, 32'h1);
    wt(32'hf, 32'h7);
    amp(8'h1b, 8'h00);
    cmp("no holdoff", 32'h0, rd & 32'h20);
    apb(1'b1, asss_pkg::A_CTRL, 32'h10);
    repeat (2) @(posedge pclk);
    cmp("loss pins", 32'h2, {rst_n_pin, power_down_pin});
    span(rst_n_pin);
    cmp("loss wait", 32'h1, n >= LONG_CYC - 2);
    wt(32'hf, 32'h9);
    end_sim();
  end
endmodule // amp_startup_shutdown_sequencer_tb

// *** verification/asss_amp_model.sv ***
`timescale 1ns/1ps
// Amplifier register file seen through the two-wire bus
module asss_amp_model (
  // Bus lines
  input wire logic scl,
  input wire logic sda,
  output logic ack_oe,
  // Last write seen
  output logic [7:0] last_reg,
  output logic [7:0] last_data,
  output int nwr
);
  logic [7:0] regs [256];
  logic [7:0] sr;
  int cnt;
  // Idle bus until the first start
  initial begin
    ack_oe = 1'b0;
    nwr = 0;
    cnt = 99;
  end
  // Start clears the bit count, stop parks it
  always @(negedge sda) if (scl) cnt = 0;
  always @(posedge sda) if (scl) cnt = 99;
  // Bits taken on the rising clock, MSB first
  always @(posedge scl) begin
    if (cnt % 9 != 8) sr = {sr[6:0], sda};
    if (cnt == 16) last_reg = sr;
    if (cnt == 25) begin
      regs[last_reg] = sr;
      last_data = sr;
      nwr++;
    end
    cnt++;
  end
  // Acknowledge each byte
  always @(negedge scl) ack_oe <= (cnt == 8 || cnt == 17 || cnt == 26);
endmodule // asss_amp_model
